// >>> src/pin_config_defs.svh
`ifndef PIN_CONFIG_DEFS_SVH
`define PIN_CONFIG_DEFS_SVH

// Register indices; byte address is four times the index
`define P1_CFG_IDX 8'hE7
`define P2H_CFG_IDX 8'hE8
`define CFG_ADR_W 12

// Reset values and implemented bits
`define P1_CFG_RESET 8'h00
`define P2H_CFG_RESET 8'h00
`define P1_CFG_MASK 8'h3F

// Field positions: pin n of a register occupies bits 2n+1..2n
`define FIELD_W 2
`define P1_PINS 3
`define P2H_PINS 4
`define P2H_FIRST_PIN 4

// Mode codes
`define CODE_SCHMITT 2'h0
`define CODE_PULLUP_OR_CMP 2'h1
`define CODE_PUSH_PULL 2'h2
`define CODE_ALT 2'h3

`endif

// >>> src/pin_config_pkg.sv
`include "pin_config_defs.svh"

package pin_config_pkg;

   // Kinds of pin: 01 means pull-up, or 01 means a comparator input
   typedef enum logic {
      KIND_PULL_ALT,
      KIND_CMP_ALT
   } pin_kind_e;

   typedef struct packed {
      logic oe;
      logic pull_up;
      logic alt01;
      logic alt11;
      logic din_en;
   } pin_mode_s;

   typedef struct packed {
      logic drive;
      logic oe;
      logic pull_up;
      logic alt01;
      logic alt11;
      logic din;
   } pin_ctrl_s;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [`CFG_ADR_W-1:0] adr;
      logic [31:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_s;

   function automatic pin_mode_s decode_mode(input pin_kind_e kind, input logic [1:0] code);
      pin_mode_s m;
      m = '0;
      m.oe = (code == `CODE_PUSH_PULL);
      m.alt11 = (code == `CODE_ALT);
      if (kind == KIND_PULL_ALT) begin
         m.pull_up = (code == `CODE_PULLUP_OR_CMP);
         m.din_en = (code == `CODE_SCHMITT) || (code == `CODE_PULLUP_OR_CMP);
      end else begin
         m.alt01 = (code == `CODE_PULLUP_OR_CMP);
         m.din_en = (code == `CODE_SCHMITT);
      end
      return m;
   endfunction

endpackage

// >>> src/pin_cell.sv
`timescale 1ns/1ps

module pin_cell #(
   parameter pin_config_pkg::pin_kind_e KIND = pin_config_pkg::KIND_PULL_ALT
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [1:0] code,
   input wire logic pin_in,
   input wire logic out_data,
   output pin_config_pkg::pin_ctrl_s ctrl
);
   import pin_config_pkg::*;

   logic sync1_r;
   logic sync1_nxt;
   logic sync2_r;
   logic sync2_nxt;
   pin_ctrl_s ctrl_r;
   pin_ctrl_s ctrl_nxt;
   pin_mode_s mode;

   always_comb begin
      sync1_nxt = pin_in;
      sync2_nxt = sync1_r;
      mode = decode_mode(KIND, code);
      ctrl_nxt.oe = mode.oe;
      // Driver only with the push-pull code
      ctrl_nxt.drive = mode.oe & out_data;
      ctrl_nxt.pull_up = mode.pull_up;
      ctrl_nxt.alt01 = mode.alt01;
      ctrl_nxt.alt11 = mode.alt11;
      // Digital value only with the Schmitt code, or with code 01 on a pull-up kind of pin
      ctrl_nxt.din = sync2_r & mode.din_en;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         ctrl_r <= '0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   assign ctrl = ctrl_r;

endmodule

// >>> src/port_pin_function_select.sv
`timescale 1ns/1ps
`include "pin_config_defs.svh"

module port_pin_function_select (
   input wire logic clk,
   input wire logic arst_n,
   input pin_config_pkg::wb_req_s wb_req,
   output pin_config_pkg::wb_rsp_s wb_rsp,
   input wire logic [2:0] p1_pin_in,
   input wire logic [2:0] p1_out_data,
   input wire logic [3:0] p2h_pin_in,
   input wire logic [3:0] p2h_out_data,
   output pin_config_pkg::pin_ctrl_s [2:0] p1_ctrl,
   output pin_config_pkg::pin_ctrl_s [3:0] p2h_ctrl,
   output logic timer_a_clock_in,
   output logic timer_a_capture_in,
   output logic comparator0_positive_in,
   output logic comparator0_negative_in,
   output logic comparator1_negative_in,
   output logic comparator2_negative_in,
   output logic comparator3_negative_in,
   output logic analog_channel_4,
   output logic analog_channel_5,
   output logic analog_channel_6,
   output logic analog_channel_7
);
   import pin_config_pkg::*;

   logic [7:0] port1_pin_config_r;
   logic [7:0] port1_pin_config_nxt;
   logic [7:0] port2_high_pin_config_r;
   logic [7:0] port2_high_pin_config_nxt;
   logic ack_r;
   logic ack_nxt;
   logic [31:0] rdat_r;
   logic [31:0] rdat_nxt;
   logic access;
   logic hit_p1;
   logic hit_p2h;

   function automatic logic reg_hit(input logic [`CFG_ADR_W-1:0] adr, input logic [7:0] idx);
      return adr[`CFG_ADR_W-1:2] == {2'b00, idx};
   endfunction

   // Answer one cycle after the request; ack drops in the following cycle
   always_comb begin
      access = wb_req.cyc & wb_req.stb & ~ack_r;
      hit_p1 = reg_hit(wb_req.adr, `P1_CFG_IDX);
      hit_p2h = reg_hit(wb_req.adr, `P2H_CFG_IDX);
      ack_nxt = access;
      port1_pin_config_nxt = port1_pin_config_r;
      port2_high_pin_config_nxt = port2_high_pin_config_r;
      rdat_nxt = rdat_r;
      if (access) begin
         rdat_nxt = 32'h0000_0000;
         if (wb_req.we && wb_req.sel[0]) begin
            if (hit_p1) begin
               // Unused bits are not stored and read as zero
               port1_pin_config_nxt = wb_req.dat[7:0] & `P1_CFG_MASK;
            end
            if (hit_p2h) begin
               port2_high_pin_config_nxt = wb_req.dat[7:0];
            end
         end else if (!wb_req.we) begin
            if (hit_p1) begin
               rdat_nxt = {24'h00_0000, port1_pin_config_r};
            end else if (hit_p2h) begin
               rdat_nxt = {24'h00_0000, port2_high_pin_config_r};
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port1_pin_config_r <= `P1_CFG_RESET;
         port2_high_pin_config_r <= `P2H_CFG_RESET;
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
      end else begin
         port1_pin_config_r <= port1_pin_config_nxt;
         port2_high_pin_config_r <= port2_high_pin_config_nxt;
         ack_r <= ack_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   assign wb_rsp.ack = ack_r;
   assign wb_rsp.dat = rdat_r;

   // Port 1 pins all use the pull-up flavour of code 01
   for (genvar i = 0; i < `P1_PINS; i++) begin : g_p1
      pin_cell #(
         .KIND(KIND_PULL_ALT)
      ) u_cell (
         .clk(clk),
         .arst_n(arst_n),
         .code(port1_pin_config_r[`FIELD_W*i +: `FIELD_W]),
         .pin_in(p1_pin_in[i]),
         .out_data(p1_out_data[i]),
         .ctrl(p1_ctrl[i])
      );
   end

   // Pins 4 and 5 use code 01 as a comparator input, pins 6 and 7 as pull-up
   for (genvar i = 0; i < `P2H_PINS; i++) begin : g_p2h
      pin_cell #(
         .KIND(i < 2 ? KIND_CMP_ALT : KIND_PULL_ALT)
      ) u_cell (
         .clk(clk),
         .arst_n(arst_n),
         .code(port2_high_pin_config_r[`FIELD_W*i +: `FIELD_W]),
         .pin_in(p2h_pin_in[i]),
         .out_data(p2h_out_data[i]),
         .ctrl(p2h_ctrl[i])
      );
   end

   // Timer sees the pin only in the two Schmitt input modes
   assign timer_a_clock_in = p1_ctrl[0].din;
   assign timer_a_capture_in = p1_ctrl[1].din;
   assign comparator0_positive_in = p1_ctrl[0].alt11;
   assign comparator0_negative_in = p1_ctrl[1].alt11;
   assign comparator1_negative_in = p1_ctrl[2].alt11;
   assign comparator2_negative_in = p2h_ctrl[0].alt01;
   assign comparator3_negative_in = p2h_ctrl[1].alt01;
   assign analog_channel_4 = p2h_ctrl[0].alt11;
   assign analog_channel_5 = p2h_ctrl[1].alt11;
   assign analog_channel_6 = p2h_ctrl[2].alt11;
   assign analog_channel_7 = p2h_ctrl[3].alt11;

endmodule

// >>> verif/port_pin_function_select_sva.sv
`timescale 1ns/1ps
module port_pin_function_select_sva (
   input logic clk,
   input logic arst_n,
   input pin_config_pkg::wb_req_s wb_req,
   input pin_config_pkg::wb_rsp_s wb_rsp,
   input logic [2:0] p1_out_data,
   input pin_config_pkg::pin_ctrl_s [2:0] p1_ctrl,
   input pin_config_pkg::pin_ctrl_s [3:0] p2h_ctrl,
   input logic timer_a_clock_in,
   input logic timer_a_capture_in,
   input logic comparator2_negative_in
);
   import pin_config_pkg::*;
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   AST_ACK_NEXT: assert property (wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack)
      else $error("request not acked next cycle");
   AST_ACK_PULSE: assert property (wb_rsp.ack |=> !wb_rsp.ack)
      else $error("ack longer than one cycle");
   AST_P1_TOP: assert property (wb_rsp.ack && $past(wb_req.adr[11:2]) == 10'h0E7
      |-> wb_rsp.dat[31:6] == 26'h0) else $error("port 1 unused bits read nonzero");
   AST_OE_ONLY: assert property (p2h_ctrl[1].oe
      |-> !(p2h_ctrl[1].alt01 || p2h_ctrl[1].alt11 || p2h_ctrl[1].din)) else $error("oe mixed");
   // Only a steady oe is judged, so the bench does not depend on register order
   AST_DRIVE: assert property (p1_ctrl[2].oe && $stable(p1_ctrl[2].oe)
      |-> p1_ctrl[2].drive == $past(p1_out_data[2])) else $error("drive not out data");
   AST_TMR_CLK: assert property (timer_a_clock_in == p1_ctrl[0].din)
      else $error("timer clock not pin 0 input");
   AST_TMR_CAP: assert property (timer_a_capture_in == p1_ctrl[1].din)
      else $error("timer capture not pin 1 input");
   AST_CMP2N: assert property (!p2h_ctrl[0].pull_up && comparator2_negative_in == p2h_ctrl[0].alt01)
      else $error("pin 4 comparator or pull-up wrong");
endmodule

bind port_pin_function_select port_pin_function_select_sva chk (.clk, .arst_n, .wb_req,
   .wb_rsp, .p1_out_data, .p1_ctrl, .p2h_ctrl, .timer_a_clock_in, .timer_a_capture_in,
   .comparator2_negative_in);

// >>> verif/port_pin_function_select_tb.sv
`timescale 1ns/1ps
module port_pin_function_select_tb;
   import pin_config_pkg::*;
   localparam logic [11:0] P1A = 12'h39C;
   localparam logic [11:0] P2A = 12'h3A0;
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   wb_req_s req = '0;
   wb_rsp_s rsp;
   pin_ctrl_s [2:0] p1_ctrl;
   pin_ctrl_s [3:0] p2h_ctrl;
   logic [10:0] side;
   logic [2:0] p1_pin = 3'h7;
   logic [2:0] p1_out = 3'h5;
   int errors = 0;
   int checks_done = 0;
   port_pin_function_select dut (.clk, .arst_n, .wb_req(req), .wb_rsp(rsp), .p1_pin_in(p1_pin),
      .p1_out_data(p1_out), .p2h_pin_in(4'hF), .p2h_out_data(4'hA), .p1_ctrl, .p2h_ctrl,
      .timer_a_clock_in(side[0]), .timer_a_capture_in(side[1]),
      .comparator0_positive_in(side[2]), .comparator0_negative_in(side[3]),
      .comparator1_negative_in(side[4]), .comparator2_negative_in(side[5]),
      .comparator3_negative_in(side[6]), .analog_channel_4(side[7]),
      .analog_channel_5(side[8]), .analog_channel_6(side[9]), .analog_channel_7(side[10]));
   initial forever #5 clk = ~clk;
   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [3:0] s,
      input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      req <= '{1'h1, 1'h1, w, s, a, d};
      do begin
         @(posedge clk);
         n++;
      end while (rsp.ack !== 1'h1 && n < 20);
      if (rsp.ack !== 1'h1) begin
         errors++;
         close_out();
      end
      q = rsp.dat;
      req <= '0;
      @(posedge clk);
   endtask
   // Bit i is pin i of port 1 for i below 3, else port 2 pin i+1
   function automatic logic [6:0] fld(input int k);
      for (int i = 0; i < 7; i++)
         fld[i] = i < 3 ? p1_ctrl[i][k] : p2h_ctrl[i-3][k];
   endfunction
   task automatic t_reset;
      logic [31:0] q;
      arst_n <= 1'h0;
      repeat (2) @(posedge clk);
      arst_n <= 1'h1;
      bus(1'h0, P1A, 4'hF, 32'h0, q);
      check("p1 reset", q, 32'h0);
      bus(1'h0, P2A, 4'hF, 32'h0, q);
      check("p2h reset", q, 32'h0);
      check("oe reset", fld(4), 32'h0);
      check("side reset", side, 32'h3);
      $display("reset test done");
   endtask
   task automatic t_codes;
      logic [31:0] q;
      logic [1:0] c;
      logic z, p, o, a;
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         {z, p, o, a} = 4'h8 >> i;
         bus(1'h1, P1A, 4'h1, {24'hFFFFFF, 2'h3, c, c, c}, q);
         bus(1'h1, P2A, 4'h1, {24'h0, c, c, c, c}, q);
         bus(1'h0, P1A, 4'hF, 32'h0, q);
         check("p1 reg", q, {26'h0, c, c, c});
         bus(1'h0, P2A, 4'hF, 32'h0, q);
         check("p2h reg", q, {24'h0, c, c, c, c});
         check("oe", fld(4), {7{o}});
         check("drive", fld(5), {7{o}} & 7'h55);
         check("pull_up", fld(3), {p, p, 2'h0, p, p, p});
         check("alt11", fld(1), {7{a}});
         check("din", fld(0), {{2{z | p}}, z, z, {3{z | p}}});
         check("side", side, {{4{a}}, {2{p}}, {3{a}}, {2{z | p}}});
      end
      $display("code test done");
   endtask
   task automatic t_refused;
      logic [31:0] q;
      bus(1'h1, P1A, 4'h1, 32'h24, q);
      bus(1'h1, P1A, 4'hE, 32'hFF, q);
      bus(1'h1, 12'h3A4, 4'hF, 32'hFF, q);
      bus(1'h0, 12'h3A4, 4'hF, 32'h0, q);
      check("unmapped", q, 32'h0);
      bus(1'h0, P1A, 4'hF, 32'h0, q);
      check("p1 kept", q, 32'h24);
      check("oe mixed", fld(4), 32'h4);
      check("pull mixed", fld(3), 32'h2);
      // Pin 0 high, pin 1 low, pin 2 high but an output; driver data cleared
      p1_pin <= 3'h5;
      p1_out <= 3'h0;
      repeat (4) @(posedge clk);
      check("din follows pin", fld(0), 32'h1);
      check("timer inputs", side[1:0], 32'h1);
      check("drive follows data", fld(5), 32'h0);
      p1_pin <= 3'h7;
      p1_out <= 3'h5;
      @(posedge clk);
      $display("refused test done");
   endtask
   initial begin
      t_reset();
      t_codes();
      t_refused();
      t_reset();
      close_out();
   end
endmodule
